// ==== shared/rps_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// ==========================================================================
// Serial frame layout
`define RPS_FRAME_BITS 16
`define RPS_RW_POS 15
`define RPS_ADDR_MSB 14
`define RPS_ADDR_LSB 8
`define RPS_DATA_MSB 7
`define RPS_RW_WRITE 1'h0
`define RPS_RW_READ 1'h1

// ==========================================================================
// Register offsets (7-bit addresses)
`define RPS_SOFT_CLEAR_ADDR 7'h60
`define RPS_PSAVE_ADDR 7'h62

// ==========================================================================
// Fields and reset values
`define RPS_SOFT_CLEAR_BIT 0
`define RPS_PSAVE_BIT 0
`define RPS_SOFT_CLEAR_RST 1'h0
`define RPS_PSAVE_RST 1'h1

// ==========================================================================
// Timing: clock period and derived cycle counts
`define RPS_CLK_NS 4
`define RPS_PIN_RST_NS 350
`define RPS_PIN_RST_CYC ((`RPS_PIN_RST_NS + `RPS_CLK_NS - 1) / `RPS_CLK_NS)
`define RPS_USE_WAIT_MS 30
`define RPS_USE_WAIT_CYC ((`RPS_USE_WAIT_MS * 1000000) / `RPS_CLK_NS)
`define RPS_SETTLE_CYC 1000

`endif

// ==== shared/rps_pkg.sv ====
// Types shared by both ends of the sequencer link
package rps_pkg;

    // ======================================================================
    // Host sequencing states
    typedef enum logic [5:0] {
        RPS_H_PIN_RST = 6'h01,
        RPS_H_SETTLE = 6'h02,
        RPS_H_PS_WR = 6'h04,
        RPS_H_USE_WAIT = 6'h08,
        RPS_H_IDLE = 6'h10,
        RPS_H_XFER = 6'h20
    } rps_host_state_t;

    typedef logic [6:0] rps_addr_t;
    typedef logic [7:0] rps_data_t;

endpackage : rps_pkg

// ==== shared/rps_if.sv ====
// Pin-level link between the host and the converter
`timescale 1ns/10ps
interface rps_if;
    logic reset_n;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic excite;
    logic angle;

    modport device (
        input reset_n, sclk, cs_n, sdi, excite,
        output sdo, angle
    );

    modport host (
        output reset_n, sclk, cs_n, sdi, excite,
        input sdo, angle
    );
endinterface : rps_if

// ==== src/rps_device.sv ====
// Converter end: reset sources, power-saving state, serial registers, angle output
//
// Operation
// - Any reset leaves device in power saving
// - Host waits settling before clearing power saving (not after a soft clear release: clears at once)
// - Host waits 30 ms after clearing
// - Soft clear 1 resets until 0 written
// - Supply drop detection forces reset
// - Only supply recovery releases drop reset
// - Host holds reset pin for minimum width
// - Host generates rectangular excitation wave
// - Angle output lags excitation by angle
// - Host times excitation to angle phase
// - Frames: 16 bits, rw, address, data
`timescale 1ns/10ps
`include "rps_regs.svh"

module rps_device #(
    parameter int ANG_W = 8,
    parameter int PER_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Link to host
    rps_if.device link,
    // Supply detector
    input wire logic supply_low_i,
    input wire logic supply_ok_i,
    // Resolver angle seen by the conversion path
    input wire logic [ANG_W-1:0] resolver_angle_i,
    // Status
    output logic core_reset_o,
    output logic power_save_o,
    output logic vdrop_reset_o
);

    // ======================================================================
    // Reset sources
    logic vdrop;
    logic hard_rst;
    logic soft_clear;
    logic power_save;

    // Drop reset is sticky: only the detector's recovery releases it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vdrop <= 1'h0;
        end else if (supply_low_i) begin
            vdrop <= 1'h1;
        end else if (supply_ok_i) begin
            vdrop <= 1'h0;
        end
    end

    // Pin, drop and bus reset clear the serial port; soft clear does not
    assign hard_rst = reset_i | ~link.reset_n | vdrop;

    // Status outputs, registered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            core_reset_o <= 1'h1;
            power_save_o <= `RPS_PSAVE_RST;
            vdrop_reset_o <= 1'h0;
        end else begin
            core_reset_o <= hard_rst | soft_clear;
            power_save_o <= power_save;
            vdrop_reset_o <= vdrop;
        end
    end

    // ======================================================================
    // Serial register port
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt;
    logic [14:0] shin;
    logic [7:0] rd_sh;
    logic wr_commit;
    rps_pkg::rps_addr_t wr_addr;
    rps_pkg::rps_data_t wr_data;
    rps_pkg::rps_addr_t rd_addr;

    // Inputs are synchronous, so a one-cycle history gives the edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_q <= 1'h0;
        end else begin
            sclk_q <= link.sclk;
        end
    end

    assign sclk_rise = link.sclk & ~sclk_q & ~link.cs_n;
    assign sclk_fall = ~link.sclk & sclk_q & ~link.cs_n;

    // Frame fields as they stand at the relevant rising edge
    assign wr_addr = shin[13:7];
    assign wr_data = {shin[6:0], link.sdi};
    assign rd_addr = {shin[5:0], link.sdi};
    // Write takes effect only at the sixteenth bit; short frames vanish
    assign wr_commit = sclk_rise && (bit_cnt == 5'h0f)
        && (shin[`RPS_RW_POS-1] == `RPS_RW_WRITE);

    // Bit counter and input shifter, MSB first
    always_ff @(posedge clk_i) begin
        if (hard_rst || link.cs_n) begin
            bit_cnt <= 5'h00;
            shin <= 15'h0000;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 5'h01;
            shin <= {shin[13:0], link.sdi};
        end
    end

    // Read data for an address
    function automatic rps_pkg::rps_data_t rd_value(input rps_pkg::rps_addr_t a);
        rps_pkg::rps_data_t v;
        v = 8'h00;
        case (a)
            `RPS_SOFT_CLEAR_ADDR: v[`RPS_SOFT_CLEAR_BIT] = soft_clear;
            `RPS_PSAVE_ADDR: v[`RPS_PSAVE_BIT] = power_save;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_value

    // Read shifter: loaded after the address, shifted on falling edges
    always_ff @(posedge clk_i) begin
        if (hard_rst || link.cs_n) begin
            rd_sh <= 8'h00;
            link.sdo <= 1'h0;
        end else if (sclk_rise && bit_cnt == 5'h07) begin
            if (shin[6] == `RPS_RW_READ) begin
                rd_sh <= rd_value(rd_addr);
            end
        end else if (sclk_fall) begin
            link.sdo <= rd_sh[7];
            rd_sh <= {rd_sh[6:0], 1'h0};
        end
    end

    // ======================================================================
    // Control registers
    // Soft clear lives behind the hard resets only, so 0 can release it
    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            soft_clear <= `RPS_SOFT_CLEAR_RST;
        end else if (wr_commit && wr_addr == `RPS_SOFT_CLEAR_ADDR) begin
            soft_clear <= wr_data[`RPS_SOFT_CLEAR_BIT];
        end
    end

    // Power saving re-arms on every reset kind and is left only by a write
    always_ff @(posedge clk_i) begin
        if (hard_rst || soft_clear) begin
            power_save <= `RPS_PSAVE_RST;
        end else if (wr_commit && wr_addr == `RPS_PSAVE_ADDR) begin
            power_save <= wr_data[`RPS_PSAVE_BIT];
        end
    end

    // ======================================================================
    // Angle output path
    logic conv_rst;
    logic ex_q;
    logic ex_rise;
    logic ex_fall;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] period;
    logic [PER_W+ANG_W-1:0] prod;
    logic [PER_W-1:0] delay;
    logic [PER_W-1:0] rise_cnt;
    logic [PER_W-1:0] fall_cnt;
    logic rise_pend;
    logic fall_pend;

    // Converter halts in reset and in power saving
    assign conv_rst = core_reset_o | power_save_o;
    assign ex_rise = link.excite & ~ex_q;
    assign ex_fall = ~link.excite & ex_q;

    // Lag is the angle's share of the last measured period
    assign prod = period * resolver_angle_i;
    assign delay = prod[PER_W+ANG_W-1:ANG_W];

    // Excitation period measured rising edge to rising edge
    always_ff @(posedge clk_i) begin
        if (conv_rst) begin
            ex_q <= link.excite; // Track the pin, or release sees a false edge
            per_cnt <= '0;
            period <= '0;
        end else begin
            ex_q <= link.excite;
            if (ex_rise) begin
                per_cnt <= '0;
                period <= per_cnt + 1'b1;
            end else if (per_cnt != '1) begin
                per_cnt <= per_cnt + 1'b1;
            end
        end
    end

    // Two countdowns, since a falling edge arrives before the rise delay ends
    always_ff @(posedge clk_i) begin
        if (conv_rst) begin
            rise_pend <= 1'h0;
            fall_pend <= 1'h0;
            rise_cnt <= '0;
            fall_cnt <= '0;
            link.angle <= 1'h0;
        end else begin
            if (ex_rise) begin
                rise_pend <= 1'h1;
                rise_cnt <= delay;
            end else if (rise_pend) begin
                if (rise_cnt == '0) begin
                    rise_pend <= 1'h0;
                    link.angle <= 1'h1;
                end else begin
                    rise_cnt <= rise_cnt - 1'b1;
                end
            end
            if (ex_fall) begin
                fall_pend <= 1'h1;
                fall_cnt <= delay;
            end else if (fall_pend) begin
                if (fall_cnt == '0) begin
                    fall_pend <= 1'h0;
                    link.angle <= 1'h0;
                end else begin
                    fall_cnt <= fall_cnt - 1'b1;
                end
            end
        end
    end

endmodule : rps_device

// ==== src/rps_host.sv ====
// Host end: reset pin, bring-up sequence, serial master, excitation and phase timing
`timescale 1ns/10ps
`include "rps_regs.svh"

module rps_host #(
    parameter int SCK_HALF = 4,
    parameter int EXC_HALF = 1250,
    parameter int SETTLE_CYC = `RPS_SETTLE_CYC,
    parameter int USE_WAIT_CYC = `RPS_USE_WAIT_CYC,
    parameter int PER_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Link to converter
    rps_if.host link,
    // User register requests
    input wire logic restart_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [6:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic ready_o,
    // Phase measurement
    output logic [PER_W-1:0] phase_o,
    output logic [PER_W-1:0] period_o
);

    // ======================================================================
    // Serial master
    logic go;
    logic [15:0] word;
    logic [15:0] tx;
    logic [7:0] rx;
    logic fr_act;
    logic fr_done;
    logic [3:0] bits;
    logic [15:0] hc;

    // Mode 0: data set while clock low, sampled at end of high phase
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.cs_n <= 1'h1;
            link.sclk <= 1'h0;
            link.sdi <= 1'h0;
            fr_act <= 1'h0;
            fr_done <= 1'h0;
            tx <= 16'h0000;
            rx <= 8'h00;
            bits <= 4'h0;
            hc <= 16'h0000;
        end else begin
            fr_done <= 1'h0;
            if (go) begin
                fr_act <= 1'h1;
                link.cs_n <= 1'h0;
                tx <= word;
                link.sdi <= word[15];
                bits <= 4'h0;
                hc <= 16'h0000;
            end else if (fr_act) begin
                hc <= hc + 16'h0001;
                if (hc == 16'(SCK_HALF - 1)) begin
                    hc <= 16'h0000;
                    link.sclk <= ~link.sclk;
                    if (link.sclk) begin
                        rx <= {rx[6:0], link.sdo};
                        tx <= {tx[14:0], 1'h0};
                        link.sdi <= tx[14];
                        bits <= bits + 4'h1;
                        if (bits == 4'hf) begin
                            fr_act <= 1'h0;
                            fr_done <= 1'h1;
                            link.cs_n <= 1'h1;
                        end
                    end
                end
            end
        end
    end

    // ======================================================================
    // Bring-up sequencing
    rps_pkg::rps_host_state_t state;
    logic [31:0] cnt;
    logic soft_wr;
    localparam logic [15:0] PS_CLEAR =
        {`RPS_RW_WRITE, `RPS_PSAVE_ADDR, 8'h00};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= rps_pkg::RPS_H_PIN_RST;
            link.reset_n <= 1'h0;
            cnt <= 32'h0;
            go <= 1'h0;
            word <= 16'h0000;
            done_o <= 1'h0;
            rdata_o <= 8'h00;
            ready_o <= 1'h0;
            soft_wr <= 1'h0;
        end else begin
            go <= 1'h0;
            done_o <= 1'h0;
            case (state)
                rps_pkg::RPS_H_PIN_RST: begin
                    link.reset_n <= 1'h0;
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(`RPS_PIN_RST_CYC - 1)) begin
                        link.reset_n <= 1'h1;
                        cnt <= 32'h0;
                        state <= rps_pkg::RPS_H_SETTLE;
                    end
                end
                rps_pkg::RPS_H_SETTLE: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(SETTLE_CYC - 1)) begin
                        go <= 1'h1;
                        word <= PS_CLEAR;
                        state <= rps_pkg::RPS_H_PS_WR;
                    end
                end
                rps_pkg::RPS_H_PS_WR: begin
                    cnt <= 32'h0;
                    if (fr_done) begin
                        state <= rps_pkg::RPS_H_USE_WAIT;
                    end
                end
                rps_pkg::RPS_H_USE_WAIT: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(USE_WAIT_CYC - 1)) begin
                        ready_o <= 1'h1;
                        state <= rps_pkg::RPS_H_IDLE;
                    end
                end
                rps_pkg::RPS_H_IDLE: begin
                    cnt <= 32'h0;
                    if (restart_i) begin
                        link.reset_n <= 1'h0;
                        ready_o <= 1'h0;
                        state <= rps_pkg::RPS_H_PIN_RST;
                    end else if (req_i) begin
                        go <= 1'h1;
                        word <= {~req_write_i, req_addr_i, req_wdata_i};
                        soft_wr <= req_write_i && req_addr_i == `RPS_SOFT_CLEAR_ADDR;
                        state <= rps_pkg::RPS_H_XFER;
                    end
                end
                rps_pkg::RPS_H_XFER: begin
                    if (fr_done) begin
                        done_o <= 1'h1;
                        rdata_o <= rx;
                        state <= rps_pkg::RPS_H_IDLE;
                        if (soft_wr && word[`RPS_SOFT_CLEAR_BIT]) begin
                            ready_o <= 1'h0;
                        end else if (soft_wr) begin
                            go <= 1'h1;
                            word <= PS_CLEAR;
                            ready_o <= 1'h0;
                            state <= rps_pkg::RPS_H_PS_WR;
                        end
                    end
                end
                default: state <= rps_pkg::RPS_H_PIN_RST;
            endcase
        end
    end

    // ======================================================================
    // Excitation wave and phase timing
    logic [15:0] exc_cnt;
    logic [PER_W-1:0] ph_cnt;
    logic ang_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            exc_cnt <= 16'h0000;
            link.excite <= 1'h0;
        end else if (exc_cnt == 16'(EXC_HALF - 1)) begin
            exc_cnt <= 16'h0000;
            link.excite <= ~link.excite;
        end else begin
            exc_cnt <= exc_cnt + 16'h0001;
        end
    end

    // Counter restarts with each excitation rise; angle rise stamps the lag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ph_cnt <= '0;
            ang_q <= 1'h0;
            phase_o <= '0;
            period_o <= '0;
        end else begin
            ang_q <= link.angle;
            if (exc_cnt == 16'(EXC_HALF - 1) && !link.excite) begin
                ph_cnt <= '0;
                period_o <= ph_cnt + 1'b1;
            end else begin
                ph_cnt <= ph_cnt + 1'b1;
            end
            if (link.angle && !ang_q) begin
                phase_o <= ph_cnt;
            end
        end
    end

endmodule : rps_host

// ==== verif/rps_asserts.sv ====
// Checker watching the host-converter link and the status lines
`timescale 1ns/10ps
`include "rps_regs.svh"

module rps_asserts #(
    parameter int SETTLE_CYC = 20,
    parameter int USE_WAIT_CYC = 200
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Link signals
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdo,
    input wire logic angle,
    // Supply and status
    input wire logic supply_low_i,
    input wire logic supply_ok_i,
    input wire logic core_reset_o,
    input wire logic power_save_o,
    input wire logic vdrop_reset_o,
    input wire logic ready_o
);
    localparam int PIN_MIN = `RPS_PIN_RST_CYC;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] awake_cnt;
    logic [4:0] rise_cnt;
    logic sclk_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ======================================================================
    // Saturating counts: pin low width, time since pin release
    always_ff @(posedge clk_i) begin
        if (reset_i || reset_n) low_cnt <= 16'h0000;
        else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i || !reset_n) high_cnt <= 16'h0000;
        else if (high_cnt != 16'hffff) high_cnt <= high_cnt + 16'h0001;
    end
    // Time since power saving was left
    always_ff @(posedge clk_i) begin
        if (reset_i || power_save_o) awake_cnt <= 16'h0000;
        else if (awake_cnt != 16'hffff) awake_cnt <= awake_cnt + 16'h0001;
    end
    // Serial clock rises inside one frame
    always_ff @(posedge clk_i) begin
        sclk_q <= sclk;
        if (reset_i || cs_n) rise_cnt <= 5'h00;
        else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
    end

    // ======================================================================
    // Properties
    property p_pin_width; $rose(reset_n) |-> low_cnt >= PIN_MIN; endproperty
    a_pin_width: assert property (p_pin_width) else $error("pin reset too short");
    property p_ps_on_reset; !reset_n |=> core_reset_o ##1 power_save_o; endproperty
    a_ps_on_reset: assert property (p_ps_on_reset) else $error("reset left power saving");
    property p_settle; $fell(power_save_o) |-> high_cnt >= SETTLE_CYC; endproperty
    a_settle: assert property (p_settle) else $error("power saving left too early");
    property p_use_wait; $rose(ready_o) |-> !power_save_o && awake_cnt >= USE_WAIT_CYC;
    endproperty
    a_use_wait: assert property (p_use_wait) else $error("ready before wait ended");
    property p_drop_in; supply_low_i |-> ##2 vdrop_reset_o && core_reset_o ##1 power_save_o;
    endproperty
    a_drop_in: assert property (p_drop_in) else $error("supply drop missed");
    property p_drop_hold; vdrop_reset_o && !(supply_ok_i && !supply_low_i) |=> vdrop_reset_o;
    endproperty
    a_drop_hold: assert property (p_drop_hold) else $error("drop reset released early");
    property p_frame_len; $rose(cs_n) |-> rise_cnt == 5'h10 && !sclk; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not 16 bits");
    property p_sdo_idle; cs_n && $past(cs_n) |-> !sdo; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("data out while deselected");
    property p_angle_quiet; power_save_o [*2] |-> !angle; endproperty
    a_angle_quiet: assert property (p_angle_quiet) else $error("angle while saving");

endmodule : rps_asserts

// ==== verif/tb.sv ====
// Bench joining host and converter ends, with scoreboard on register reads
`timescale 1ns/10ps
`include "rps_regs.svh"

module tb;
    localparam int SETTLE = 20;
    localparam int USE_WAIT = 200;
    localparam int EXC_HALF = 50;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic supply_low_i = 1'b0;
    logic supply_ok_i = 1'b1;
    logic [7:0] resolver_angle_i = 8'h00;
    logic restart_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [6:0] req_addr_i = 7'h00;
    logic [7:0] req_wdata_i = 8'h00;
    logic done_o, ready_o, core_reset_o, power_save_o, vdrop_reset_o;
    logic [7:0] rdata_o;
    logic [15:0] phase_o, period_o;
    logic [8:0] exp_q[$];
    logic [8:0] exp_head;
    int err_total = 0;
    int n_compared = 0;
    int k, dly;
    logic [6:0] addr;
    logic [7:0] ang;

    rps_if link_if();
    rps_host #(.SETTLE_CYC(SETTLE), .USE_WAIT_CYC(USE_WAIT), .EXC_HALF(EXC_HALF)) rps_host_inst (
        .clk_i(clk_i), .reset_i(reset_i), .link(link_if.host), .restart_i(restart_i),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .done_o(done_o), .rdata_o(rdata_o), .ready_o(ready_o),
        .phase_o(phase_o), .period_o(period_o));
    rps_device rps_device_inst (
        .clk_i(clk_i), .reset_i(reset_i), .link(link_if.device), .supply_low_i(supply_low_i),
        .supply_ok_i(supply_ok_i), .resolver_angle_i(resolver_angle_i),
        .core_reset_o(core_reset_o), .power_save_o(power_save_o),
        .vdrop_reset_o(vdrop_reset_o));
    rps_asserts #(.SETTLE_CYC(SETTLE), .USE_WAIT_CYC(USE_WAIT)) rps_asserts_inst (
        .clk_i(clk_i), .reset_i(reset_i), .reset_n(link_if.reset_n), .sclk(link_if.sclk),
        .cs_n(link_if.cs_n), .sdo(link_if.sdo), .angle(link_if.angle),
        .supply_low_i(supply_low_i), .supply_ok_i(supply_ok_i), .core_reset_o(core_reset_o),
        .power_save_o(power_save_o), .vdrop_reset_o(vdrop_reset_o), .ready_o(ready_o));

    // ======================================================================
    // Clock, 4 ns period
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cycles

    // Bounded wait for bring-up to finish
    task automatic wait_ready();
        int i;
        for (i = 0; i < 2000 && ready_o !== 1'b1; i++) @(negedge clk_i);
        check("ready", 16'(ready_o), 16'h1);
    endtask : wait_ready

    // One register frame; expectation noted before the request goes out
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        input logic chk, input logic [7:0] exp);
        int i;
        exp_q.push_back({chk, exp});
        @(posedge clk_i);
        req_i <= 1'b1;
        req_write_i <= wr;
        req_addr_i <= a;
        req_wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        for (i = 0; i < 400 && done_o !== 1'b1; i++) @(negedge clk_i);
        check("done", 16'(done_o), 16'h1);
        @(negedge clk_i);
    endtask : xfer

    // Scoreboard: oldest note against each completed frame
    always @(negedge clk_i) begin
        if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected_done", 16'h1, 16'h0);
            end else begin
                exp_head = exp_q.pop_front();
                if (exp_head[8]) check("rdata", 16'(rdata_o), 16'(exp_head[7:0]));
            end
        end
    end

    // Watchdog, far beyond the roughly 6000 cycles the run needs
    initial begin
        cycles(40000);
        err_total++;
        results();
    end

    // ======================================================================
    // Main sequence
    initial begin
        void'($urandom(32'he452fae9));
        cycles(20);
        reset_i <= 1'b0;
        cycles(3);
        @(negedge clk_i);
        check("ps_after_reset", 16'(power_save_o), 16'h1);
        wait_ready();
        check("ps_cleared", 16'(power_save_o), 16'h0);
        check("core_running", 16'(core_reset_o), 16'h0);
        // Unmapped places: writes vanish, reads give zero
        for (k = 0; k < 4; k++) begin
            addr = 7'($urandom_range(127, 0));
            if (addr == `RPS_SOFT_CLEAR_ADDR || addr == `RPS_PSAVE_ADDR) addr = 7'h11;
            xfer(1'b1, addr, 8'($urandom), 1'b0, 8'h00);
            xfer(1'b0, addr, 8'h00, 1'b1, 8'h00);
        end
        xfer(1'b0, `RPS_PSAVE_ADDR, 8'h00, 1'b1, 8'h00);
        // Soft clear held; port stays alive, power-save write ignored
        xfer(1'b1, `RPS_SOFT_CLEAR_ADDR, 8'h01, 1'b0, 8'h00);
        cycles(2);
        @(negedge clk_i);
        check("soft_core", 16'(core_reset_o), 16'h1);
        check("soft_ps", 16'(power_save_o), 16'h1);
        xfer(1'b0, `RPS_SOFT_CLEAR_ADDR, 8'h00, 1'b1, 8'h01);
        xfer(1'b1, `RPS_PSAVE_ADDR, 8'h00, 1'b0, 8'h00);
        xfer(1'b0, `RPS_PSAVE_ADDR, 8'h00, 1'b1, 8'h01);
        check("soft_still", 16'(core_reset_o), 16'h1);
        xfer(1'b1, `RPS_SOFT_CLEAR_ADDR, 8'h00, 1'b0, 8'h00);
        cycles(4);
        @(negedge clk_i);
        check("soft_free", 16'(core_reset_o), 16'h0);
        check("ready_waits", 16'(ready_o), 16'h0);
        wait_ready();
        check("soft_ps_off", 16'(power_save_o), 16'h0);
        // Supply drop: register writes cannot release it
        @(posedge clk_i);
        supply_ok_i <= 1'b0;
        supply_low_i <= 1'b1;
        cycles(3);
        @(negedge clk_i);
        check("drop_in", 16'(vdrop_reset_o), 16'h1);
        check("drop_core", 16'(core_reset_o), 16'h1);
        @(posedge clk_i);
        supply_low_i <= 1'b0;
        // Power-save write, since a soft-clear write sends the host back into bring-up
        xfer(1'b1, `RPS_PSAVE_ADDR, 8'h00, 1'b0, 8'h00);
        xfer(1'b0, `RPS_PSAVE_ADDR, 8'h00, 1'b1, 8'h00);
        check("drop_hold", 16'(vdrop_reset_o), 16'h1);
        @(posedge clk_i);
        supply_ok_i <= 1'b1;
        cycles(3);
        @(negedge clk_i);
        check("drop_out", 16'(vdrop_reset_o), 16'h0);
        check("drop_ps", 16'(power_save_o), 16'h1);
        @(posedge clk_i);
        restart_i <= 1'b1;
        cycles(1);
        restart_i <= 1'b0;
        cycles(4);
        wait_ready();
        check("restart_ps", 16'(power_save_o), 16'h0);
        // Angle lag grows with angle: zero, half turn, random
        for (k = 0; k < 3; k++) begin
            ang = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($urandom_range(191, 0));
            @(posedge clk_i);
            resolver_angle_i <= ang;
            cycles(16 * EXC_HALF);
            @(negedge clk_i);
            dly = (2 * EXC_HALF * int'(ang)) / 256;
            check("period", period_o, 16'(2 * EXC_HALF));
            check("phase", 16'(phase_o >= dly + 1 && phase_o <= dly + 5), 16'h1);
        end
        check("queue_left", 16'(exp_q.size()), 16'h0);
        results();
    end

endmodule : tb
